// ---- shared/dma_req_pkg.sv ----
package dma_req_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int CNT_W = 32;
   localparam int LVL_W = 16;

   localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_CFG = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;

   localparam int CTRL_GO = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_RUNNING = 2;

   localparam int CFG_FREE = 0;
   localparam int CFG_READ = 1;
   localparam int CFG_BYTE = 2;
   localparam int CFG_BURST_LO = 3;
   localparam int CFG_BURST_HI = 4;
   localparam int CFG_REQ_HIGH = 5;
   localparam int CFG_ACK_HIGH = 6;
   localparam int CFG_SHORT_DIS = 7;
   localparam int CFG_W = 8;

   localparam int ST_CMP = 0;
   localparam int ST_CNTUP = 1;

   localparam logic [LVL_W-1:0] LVL_ZERO = 16'h0000;
   localparam logic [LVL_W-1:0] LVL_ONE = 16'h0001;
   localparam logic [LVL_W-1:0] LVL_WORD = 16'h0002;
   localparam logic [LVL_W-1:0] BURST_SEL1 = 16'h0004;
   localparam logic [LVL_W-1:0] BURST_SEL2 = 16'h0008;
   localparam logic [LVL_W-1:0] BURST_SEL3 = 16'h0010;

   localparam logic [1:0] STEP_BYTE = 2'h1;
   localparam logic [1:0] STEP_WORD = 2'h2;
   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h00000000;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h00000001;
   localparam logic [CNT_W-1:0] CNT_RST = 32'h00000000;

   typedef struct packed {
      logic short_dis;
      logic ack_high;
      logic req_high;
      logic [1:0] burst;
      logic byte_mode;
      logic read_dir;
      logic free_run;
   } cfg_t;

   localparam cfg_t CFG_RST = '0;

   typedef struct packed {
      logic [LVL_W-1:0] ready_bytes;
      logic ext_ready;
      logic [LVL_W-1:0] ep_bytes;
      logic short_pkt;
      logic usb_dev;
   } fifo_view_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ARMED = 4'b0010,
      ST_BURST = 4'b0100,
      ST_GAP = 4'b1000
   } req_state_t;

   function automatic logic [LVL_W-1:0] burst_len(input logic [1:0] sel);
      case (sel)
         2'h1: burst_len = BURST_SEL1;
         2'h2: burst_len = BURST_SEL2;
         2'h3: burst_len = BURST_SEL3;
         default: burst_len = LVL_ZERO;
      endcase
   endfunction

endpackage

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync
   import dma_req_pkg::*;
#(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] rst_val,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out
);

   // The first stage feeds only the second; nothing else may look at it.
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_ff[i] <= 1'b1;
               sync_ff[i] <= 1'b1;
            end else if (ce) begin
               meta_ff[i] <= pin_in[i];
               sync_ff[i] <= meta_ff[i];
            end
         end
      end
   endgenerate

   assign pin_out = sync_ff ^ ~rst_val;

endmodule // pin_sync

// ---- logic/req_condition.sv ----
`timescale 1ns/1ps
module req_condition
   import dma_req_pkg::*;
(
   input cfg_t cfg,
   input wire logic [LVL_W-1:0] ready_bytes,
   input wire logic ext_ready,
   input wire logic [CNT_W-1:0] count,
   output logic plain_ok,
   output logic burst_ok,
   output logic [LVL_W-1:0] burst_bytes
);

   logic count_mode;
   logic side_ready;
   logic count_left;
   logic count_small;
   logic [LVL_W-1:0] min_ready;
   logic [CNT_W-1:0] ready_w;
   logic [CNT_W-1:0] burst_w;

   always_comb begin
      count_mode = ~cfg.free_run;
      side_ready = ~cfg.read_dir | ext_ready;
      count_left = count != CNT_ZERO;
      min_ready = cfg.byte_mode ? LVL_ONE : LVL_WORD;
      ready_w = CNT_W'(ready_bytes);
      burst_bytes = burst_len(cfg.burst);
      burst_w = CNT_W'(burst_bytes);
      count_small = count_mode && count_left && (count < burst_w);
      plain_ok = 1'b0;
      if (count_mode) begin
         // In word mode a lone byte is only worth a request when it finishes the count.
         plain_ok = count_left && side_ready && ((ready_bytes >= min_ready)
            || (ready_bytes == LVL_ONE && count == CNT_ONE));
      end else begin
         plain_ok = side_ready && (ready_bytes >= min_ready);
      end
      burst_ok = side_ready && ((ready_bytes >= burst_bytes)
         || (count_small && ready_w >= count));
      if (count_mode && !count_left) begin
         burst_ok = 1'b0;
      end
   end

endmodule // req_condition

// ---- logic/dma_req_channel.sv ----
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module dma_req_channel
   import dma_req_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input fifo_view_t fifo,
   input wire logic dma_acknowledge_n,
   input wire logic dma_strobe_n,
   output logic dma_request_n,
   output logic xfer_pulse,
   output logic [1:0] xfer_bytes,
   output logic endpoint_hold_off
);

////////////////////////////////////////////////////////////////////////////////

   cfg_t cfg_ff;
   logic running_ff;
   logic [CNT_W-1:0] count_ff;
   logic cmp_ff;
   logic cntup_ff;
   logic [DATA_W-1:0] rdata_ff;
   req_state_t state_ff;
   req_state_t nxt_state;
   logic [LVL_W-1:0] burst_left_ff;
   logic [LVL_W-1:0] nxt_burst_left;
   logic req_pin_ff;
   logic strobe_seen_ff;
   logic xfer_pulse_ff;
   logic [1:0] xfer_bytes_ff;
   logic hold_ff;
   logic hold_seen_ff;

   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic go_wr;
   logic stop_wr;
   logic count_wr;
   logic status_wr;
   logic [1:0] pin_raw;
   logic [1:0] pin_rst;
   logic [1:0] pin_s;
   logic ack_act;
   logic strobe_act;
   logic access;
   logic count_mode;
   logic [1:0] step;
   logic [CNT_W-1:0] step_w;
   logic [CNT_W:0] up_sum;
   logic last_access;
   logic sw_stop;
   logic plain_ok;
   logic burst_ok;
   logic [LVL_W-1:0] burst_bytes;
   logic burst_on;
   logic nxt_req;
   logic hold_cond;

////////////////////////////////////////////////////////////////////////////////
// Register bus. Answers in the access phase, with a wait state for every cycle that ce is low.

   assign pready = ce;
   assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CFG)
      || (paddr == OFS_COUNT) || (paddr == OFS_STATUS);
   assign pslverr = psel & penable & ~mapped;
   assign wr_en = ce & psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign go_wr = wr_en && paddr == OFS_CTRL && pwdata[CTRL_GO];
   assign stop_wr = wr_en && paddr == OFS_CTRL && pwdata[CTRL_STOP];
   assign count_wr = wr_en && paddr == OFS_COUNT;
   assign status_wr = wr_en && paddr == OFS_STATUS;
   assign prdata = rdata_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= '0;
      end else if (ce && rd_setup) begin
         rdata_ff <= '0;
         case (paddr)
            OFS_CTRL: rdata_ff[CTRL_RUNNING] <= running_ff;
            OFS_CFG: rdata_ff[CFG_W-1:0] <= {cfg_ff.short_dis, cfg_ff.ack_high,
               cfg_ff.req_high, cfg_ff.burst, cfg_ff.byte_mode, cfg_ff.read_dir,
               cfg_ff.free_run};
            OFS_COUNT: rdata_ff <= count_ff;
            OFS_STATUS: rdata_ff[ST_CNTUP:ST_CMP] <= {cntup_ff, cmp_ff};
            default: rdata_ff <= '0;
         endcase
      end
   end

   // Changing the mode under a running transfer would make the count meaningless.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_ff <= CFG_RST;
      end else if (ce && wr_en && paddr == OFS_CFG && !running_ff) begin
         cfg_ff.free_run <= pwdata[CFG_FREE];
         cfg_ff.read_dir <= pwdata[CFG_READ];
         cfg_ff.byte_mode <= pwdata[CFG_BYTE];
         cfg_ff.burst <= pwdata[CFG_BURST_HI:CFG_BURST_LO];
         cfg_ff.req_high <= pwdata[CFG_REQ_HIGH];
         cfg_ff.ack_high <= pwdata[CFG_ACK_HIGH];
         cfg_ff.short_dis <= pwdata[CFG_SHORT_DIS];
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Pins from the external controller are asynchronous to clk.

   assign pin_raw = {dma_strobe_n, dma_acknowledge_n};
   assign pin_rst = '1;

   pin_sync #(
      .W(2)
   ) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .rst_val(pin_rst),
      .pin_in(pin_raw),
      .pin_out(pin_s)
   );

   assign ack_act = cfg_ff.ack_high ? pin_s[0] : ~pin_s[0];
   assign strobe_act = ~pin_s[1];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobe_seen_ff <= 1'b0;
      end else if (ce) begin
         strobe_seen_ff <= strobe_act;
      end
   end

   // One access is counted at the leading edge of each acknowledged strobe.
   assign access = running_ff & ack_act & strobe_act & ~strobe_seen_ff;

////////////////////////////////////////////////////////////////////////////////
// Transfer counting.

   assign count_mode = ~cfg_ff.free_run;
   assign step = (cfg_ff.byte_mode || (count_mode && count_ff == CNT_ONE))
      ? STEP_BYTE : STEP_WORD;
   assign step_w = CNT_W'(step);
   assign up_sum = {1'b0, count_ff} + {1'b0, step_w};
   assign last_access = access && count_mode && count_ff <= step_w;
   assign sw_stop = stop_wr;

   // The count is frozen against software while the channel runs.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_ff <= CNT_RST;
      end else if (ce) begin
         if (access && count_mode) begin
            count_ff <= last_access ? CNT_ZERO : count_ff - step_w;
         end else if (access) begin
            count_ff <= up_sum[CNT_W-1:0];
         end else if (count_wr && !running_ff) begin
            count_ff <= pwdata;
         end
      end
   end

   // Stop wins over go when both land in one write.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         running_ff <= 1'b0;
      end else if (ce) begin
         if (sw_stop) begin
            running_ff <= 1'b0;
         end else if (last_access) begin
            running_ff <= 1'b0;
         end else if (go_wr) begin
            running_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xfer_pulse_ff <= 1'b0;
         xfer_bytes_ff <= '0;
      end else if (ce) begin
         xfer_pulse_ff <= access;
         if (access) begin
            xfer_bytes_ff <= step;
         end
      end
   end

   assign xfer_pulse = xfer_pulse_ff;
   assign xfer_bytes = xfer_bytes_ff;

////////////////////////////////////////////////////////////////////////////////
// Event flags. Hardware setting beats a software clear in the same cycle.

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmp_ff <= 1'b0;
      end else if (ce) begin
         if (running_ff && (sw_stop || last_access)) begin
            cmp_ff <= 1'b1;
         end else if (status_wr && pwdata[ST_CMP]) begin
            cmp_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cntup_ff <= 1'b0;
      end else if (ce) begin
         if (access && !count_mode && up_sum[CNT_W]) begin
            cntup_ff <= 1'b1;
         end else if (status_wr && pwdata[ST_CNTUP]) begin
            cntup_ff <= 1'b0;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Endpoint hold-off for count-mode reads while operating as a USB device.

   assign hold_cond = running_ff && count_mode && cfg_ff.read_dir && fifo.usb_dev
      && ((CNT_W'(fifo.ep_bytes) > count_ff)
      || (fifo.short_pkt && !cfg_ff.short_dis));

   // Pulsed once per run so the endpoint logic can latch its hold bit.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_ff <= 1'b0;
         hold_seen_ff <= 1'b0;
      end else if (ce) begin
         hold_ff <= hold_cond && !hold_seen_ff;
         if (!running_ff) begin
            hold_seen_ff <= 1'b0;
         end else if (hold_cond) begin
            hold_seen_ff <= 1'b1;
         end
      end
   end

   assign endpoint_hold_off = hold_ff;

////////////////////////////////////////////////////////////////////////////////
// Request generation.

   req_condition u_req_condition (
      .cfg(cfg_ff),
      .ready_bytes(fifo.ready_bytes),
      .ext_ready(fifo.ext_ready),
      .count(count_ff),
      .plain_ok(plain_ok),
      .burst_ok(burst_ok),
      .burst_bytes(burst_bytes)
   );

   assign burst_on = cfg_ff.burst != 2'h0;

   always_comb begin
      nxt_state = state_ff;
      nxt_burst_left = burst_left_ff;
      case (state_ff)
         ST_IDLE: begin
            if (running_ff) begin
               nxt_state = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (burst_on && burst_ok) begin
               nxt_state = ST_BURST;
               nxt_burst_left = (count_mode && count_ff < CNT_W'(burst_bytes))
                  ? count_ff[LVL_W-1:0] : burst_bytes;
            end
         end
         ST_BURST: begin
            if (access) begin
               if (burst_left_ff <= LVL_W'(step)) begin
                  nxt_state = ST_GAP;
                  nxt_burst_left = LVL_ZERO;
               end else begin
                  nxt_burst_left = burst_left_ff - LVL_W'(step);
               end
            end
         end
         ST_GAP: begin
            nxt_state = ST_ARMED;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (!running_ff || sw_stop || last_access) begin
         nxt_state = ST_IDLE;
         nxt_burst_left = LVL_ZERO;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         burst_left_ff <= LVL_ZERO;
      end else if (ce) begin
         state_ff <= nxt_state;
         burst_left_ff <= nxt_burst_left;
      end
   end

   // The pin drops on the edge that takes the stop, never ahead of the halt.
   always_comb begin
      nxt_req = 1'b0;
      if (nxt_state == ST_BURST) begin
         nxt_req = 1'b1;
      end else if (nxt_state == ST_ARMED && !burst_on) begin
         nxt_req = plain_ok;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_pin_ff <= 1'b1;
      end else if (ce) begin
         req_pin_ff <= cfg_ff.req_high ? nxt_req : ~nxt_req;
      end
   end

   assign dma_request_n = req_pin_ff;

endmodule // dma_req_channel

// ---- bench/dma_req_channel_properties.sv ----
`timescale 1ns/1ps
module dma_req_channel_properties
   import dma_req_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input fifo_view_t fifo,
   input wire logic dma_request_n,
   input wire logic xfer_pulse,
   input wire logic [1:0] xfer_bytes,
   input wire logic endpoint_hold_off
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // Shadow of the setup word; it tracks the design only because setup is written while idle.
   cfg_t cfg_ff;
   logic req_on;
   logic mapped;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_ff <= CFG_RST;
      end else if (psel && penable && pwrite && ce && paddr == OFS_CFG) begin
         cfg_ff <= cfg_t'(pwdata[CFG_W-1:0]);
      end
   end
   // Only the low-active request is judged, so a polarity switch never looks like an edge.
   assign req_on = !cfg_ff.req_high && !dma_request_n;
   assign mapped = paddr inside {OFS_CTRL, OFS_CFG, OFS_COUNT, OFS_STATUS};
   sequence s_any_ready;
      $past(fifo.ready_bytes, 1) != LVL_ZERO || $past(fifo.ready_bytes, 2) != LVL_ZERO;
   endsequence
   sequence s_word_ready;
      $past(fifo.ready_bytes, 1) >= LVL_WORD || $past(fifo.ready_bytes, 2) >= LVL_WORD
         || $past(fifo.ready_bytes, 3) >= LVL_WORD;
   endsequence
   sequence s_gap;
      !req_on [*2];
   endsequence
   ////////////////////////////////////////
   a_pready_ce: assert property (pready == ce)
      else $error("pready differs from ce");
   a_slverr_unmapped: assert property (psel && penable |-> pslverr == !mapped)
      else $error("pslverr wrong for address");
   a_xfer_single: assert property (xfer_pulse |=> !xfer_pulse)
      else $error("access counted twice");
   a_req_rise_fifo: assert property ($rose(req_on) |-> s_any_ready)
      else $error("request rose with empty fifo");
   a_free_word_only: assert property (
      $rose(req_on) && cfg_ff.free_run && !cfg_ff.byte_mode |-> s_word_ready)
      else $error("free run request with one byte");
   a_req_empty_drop: assert property (
      (fifo.ready_bytes == LVL_ZERO && cfg_ff.burst == 2'h0) [*3] |-> !req_on)
      else $error("request held with no fifo room");
   a_burst_gap: assert property ($fell(req_on) && cfg_ff.burst != 2'h0 |-> s_gap)
      else $error("burst gap too short");
   a_word_steps: assert property (
      xfer_pulse && cfg_ff.free_run && !cfg_ff.byte_mode |-> xfer_bytes == STEP_WORD)
      else $error("free run moved a single byte");
   a_byte_steps: assert property (
      xfer_pulse && cfg_ff.byte_mode |-> xfer_bytes == STEP_BYTE)
      else $error("byte mode moved a word");
   a_hold_role: assert property (
      endpoint_hold_off |-> cfg_ff.read_dir && !cfg_ff.free_run && $past(fifo.usb_dev))
      else $error("endpoint hold outside count read");
endmodule // dma_req_channel_properties

// ---- bench/dma_master_model.sv ----
`timescale 1ns/1ps
module dma_master_model (
   input wire logic clk,
   input wire logic enable,
   input wire logic slow,
   input wire logic req_high,
   input wire logic ack_high,
   input wire logic dma_request_n,
   output logic dma_acknowledge_n,
   output logic dma_strobe_n,
   output logic req_at_release
);
   logic asked;
   assign asked = req_high ? dma_request_n : !dma_request_n;
   initial begin
      dma_acknowledge_n = 1'b1;
      dma_strobe_n = 1'b1;
      req_at_release = 1'b0;
      forever begin
         @(posedge clk);
         if (enable && asked) begin
            dma_acknowledge_n <= ack_high;
            repeat (slow ? 6 : 2) @(posedge clk);
            dma_strobe_n <= 1'b0;
            // Long strobe so that the final access must see the request fall beneath it.
            repeat (5) @(posedge clk);
            req_at_release <= asked;
            dma_strobe_n <= 1'b1;
            repeat (3) @(posedge clk);
         end else begin
            dma_acknowledge_n <= !ack_high;
         end
      end
   end
endmodule // dma_master_model

// ---- bench/test_fifo_dma_request_channel.sv ----
`timescale 1ns/1ps
module test_fifo_dma_request_channel
   import dma_req_pkg::*;
;
   logic clk, rst, ce, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, q, b;
   fifo_view_t fv;
   logic ack_n, strobe_n, request_n, xfer_pulse, hold, en, slow, rq_hi, ak_hi, late, e;
   logic [1:0] xfer_bytes, last_bytes;
   logic [DATA_W-1:0] bytes_sum;
   int n_hold;
   int n_xfer, num_errors, tests_run, n0;
   dma_req_channel dma_req_channel_inst (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fifo(fv), .dma_acknowledge_n(ack_n),
      .dma_strobe_n(strobe_n), .dma_request_n(request_n), .xfer_pulse(xfer_pulse),
      .xfer_bytes(xfer_bytes), .endpoint_hold_off(hold));
   dma_master_model dma_master_model_inst (.clk(clk), .enable(en), .slow(slow),
      .req_high(rq_hi), .ack_high(ak_hi), .dma_request_n(request_n),
      .dma_acknowledge_n(ack_n), .dma_strobe_n(strobe_n), .req_at_release(late));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (xfer_pulse === 1'b1) begin
         n_xfer <= n_xfer + 1;
         bytes_sum <= bytes_sum + xfer_bytes;
         last_bytes <= xfer_bytes;
      end
      if (hold === 1'b1) n_hold <= n_hold + 1;
   end
   ////////////////////////////////////////
   task automatic final_report;
      if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] rq, output logic re);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] rq;
      logic re;
      apb(1'b1, a, d, rq, re);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
      logic [DATA_W-1:0] rq;
      logic re;
      apb(1'b0, a, '0, rq, re);
      check(rq, x);
   endtask
   // A request seen active at any clock inside the window is a mismatch, not only the level at its end.
   task automatic quiet(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge clk);
         if ((rq_hi ? request_n : !request_n) !== 1'b0) seen = 1'b1;
      end
      check(seen, 1'b0);
   endtask
   task automatic until_stopped;
      logic [DATA_W-1:0] rq;
      logic re;
      rq = '1;
      for (int i = 0; i < 100 && rq[CTRL_RUNNING] !== 1'b0; i++) apb(1'b0, OFS_CTRL, '0, rq, re);
      check(rq, 32'h0);
   endtask
   task automatic wait_xfer(input int n);
      for (int i = 0; i < 3000 && n_xfer < n; i++) @(posedge clk);
   endtask
   // The far master is parked before the stop write, as software must do.
   task automatic halt_stop;
      en <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 100 && ack_n !== !ak_hi; i++) @(posedge clk);
      wr(OFS_CTRL, 32'h2);
   endtask
   ////////////////////////////////////////
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      fv = '{ready_bytes: LVL_ONE, ext_ready: 1'b1, ep_bytes: LVL_ZERO, short_pkt: 1'b0,
         usb_dev: 1'b0};
      en = 1'b0;
      slow = 1'b0;
      rq_hi = 1'b0;
      ak_hi = 1'b0;
      bytes_sum = '0;
      n_hold = 0;
      n_xfer = 0;
      num_errors = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check(request_n, 1'b1);
      ce <= 1'b0;
      @(posedge clk);
      check(pready, 1'b0);
      ce <= 1'b1;
      rd(OFS_CTRL, 32'h0);
      rd(OFS_STATUS, 32'h0);
      apb(1'b0, 12'h010, '0, q, e);
      check(e, 1'b1);
      b = bytes_sum;
      wr(OFS_COUNT, 32'h3);
      en <= 1'b1;
      wr(OFS_CTRL, 32'h1);
      rd(OFS_CTRL, 32'h4);
      quiet(20);
      n0 = n_xfer;
      fv.ready_bytes <= 16'h0004;
      wait_xfer(n0 + 1);
      fv.ready_bytes <= LVL_ONE;
      until_stopped();
      check(bytes_sum - b, 32'h3);
      check(last_bytes, 2'h1);
      rd(OFS_STATUS, 32'h1);
      wr(OFS_STATUS, 32'h3);
      rd(OFS_STATUS, 32'h0);
      check(late, 1'b0);
      wr(OFS_COUNT, 32'hfffffffc);
      wr(OFS_CFG, 32'h1);
      fv.ready_bytes <= LVL_ONE;
      n0 = n_xfer;
      en <= 1'b1;
      wr(OFS_CTRL, 32'h1);
      quiet(20);
      fv.ready_bytes <= 16'h0008;
      wait_xfer(n0 + 3);
      fv.ready_bytes <= LVL_ZERO;
      repeat (2) @(posedge clk);
      quiet(10);
      fv.ready_bytes <= 16'h0008;
      rd(OFS_CTRL, 32'h4);
      halt_stop();
      repeat (3) @(posedge clk);
      quiet(10);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_STATUS, 32'h3);
      wr(OFS_STATUS, 32'h3);
      wr(OFS_COUNT, 32'h2);
      wr(OFS_CFG, 32'h6);
      fv <= '{ready_bytes: 16'h0004, ext_ready: 1'b0, ep_bytes: 16'h0008, short_pkt: 1'b0,
         usb_dev: 1'b1};
      b = bytes_sum;
      n0 = n_xfer;
      slow <= 1'b1;
      en <= 1'b1;
      wr(OFS_CTRL, 32'h1);
      quiet(20);
      check(n_hold, 32'h1);
      fv.ext_ready <= 1'b1;
      until_stopped();
      check(bytes_sum - b, 32'h2);
      check(n_xfer - n0, 32'h2);
      rd(OFS_STATUS, 32'h1);
      wr(OFS_COUNT, 32'h2);
      fv.ext_ready <= 1'b0;
      fv.ep_bytes <= LVL_ZERO;
      fv.short_pkt <= 1'b1;
      wr(OFS_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      check(n_hold, 32'h2);
      wr(OFS_CTRL, 32'h2);
      wr(OFS_CFG, 32'h86);
      wr(OFS_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      check(n_hold, 32'h2);
      wr(OFS_CTRL, 32'h2);
      fv.short_pkt <= 1'b0;
      wr(OFS_STATUS, 32'h3);
      fv.usb_dev <= 1'b0;
      slow <= 1'b0;
      wr(OFS_CFG, 32'h9);
      fv.ready_bytes <= 16'h0002;
      n0 = n_xfer;
      wr(OFS_CTRL, 32'h1);
      quiet(20);
      fv.ready_bytes <= 16'h0008;
      wait_xfer(n0 + 4);
      check(n_xfer - n0 >= 4, 1'b1);
      halt_stop();
      rd(OFS_STATUS, 32'h1);
      wr(OFS_STATUS, 32'h3);
      wr(OFS_COUNT, 32'h4);
      wr(OFS_CFG, 32'h18);
      b = bytes_sum;
      en <= 1'b1;
      wr(OFS_CTRL, 32'h1);
      until_stopped();
      check(bytes_sum - b, 32'h4);
      wr(OFS_STATUS, 32'h3);
      en <= 1'b0;
      wr(OFS_CFG, 32'h61);
      rq_hi <= 1'b1;
      ak_hi <= 1'b1;
      @(posedge clk);
      check(request_n, 1'b0);
      n0 = n_xfer;
      en <= 1'b1;
      wr(OFS_CTRL, 32'h1);
      wait_xfer(n0 + 2);
      check(n_xfer - n0 >= 2, 1'b1);
      halt_stop();
      rd(OFS_CTRL, 32'h0);
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      final_report();
   end
endmodule // test_fifo_dma_request_channel
bind dma_req_channel dma_req_channel_properties dma_req_channel_properties_inst (.clk(clk),
   .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .fifo(fifo),
   .dma_request_n(dma_request_n), .xfer_pulse(xfer_pulse), .xfer_bytes(xfer_bytes),
   .endpoint_hold_off(endpoint_hold_off));
